// file: cies_pkg.sv
//----------------------------------------------------------------------
// Instruction subset execution constants
//----------------------------------------------------------------------
// Behaviour
// (RQ1) Clear accumulator writes zero, sets zero flag
// (RQ2) 7-bit file address, destination bit selects target
// (RQ3) Decrement-skip stores result, skips on zero
// (RQ4) Increment-skip stores result, skips on zero
// (RQ5) Branch loads literal and latch bits 6..3
// (RQ6) Branch takes two cycles, flushes fetched word
// (RQ7) Literal OR into accumulator, updates zero flag
// (RQ8) Increment stores at destination, updates zero flag
// (RQ9) Zero flag from 8-bit result, wrap modulo 256
package cies_pkg;

    //------------------------------------------------------------------
    // Opcode encodings (14-bit word)
    //------------------------------------------------------------------
    localparam logic [13:0] CIES_CLEAR_ACC_WORD = 14'h0103;
    localparam logic [5:0]  CIES_DEC_SKIP_OPC   = 6'h0b;
    localparam logic [5:0]  CIES_INC_SKIP_OPC   = 6'h0f;
    localparam logic [5:0]  CIES_INC_FILE_OPC   = 6'h0a;
    localparam logic [5:0]  CIES_OR_LIT_OPC     = 6'h38;
    localparam logic [2:0]  CIES_BRANCH_OPC     = 3'h5;

    //------------------------------------------------------------------
    // Field positions and widths
    //------------------------------------------------------------------
    localparam int CIES_FILE_ADDR_W = 7;
    localparam int CIES_DEST_BIT    = 7;
    localparam int CIES_LIT_W       = 11;
    localparam int CIES_PC_W        = 15;
    localparam int CIES_LATCH_LO    = 3;
    localparam int CIES_LATCH_HI    = 6;

    //------------------------------------------------------------------
    // Reset values
    //------------------------------------------------------------------
    localparam logic [7:0]  CIES_ACC_RST  = 8'h00;
    localparam logic [14:0] CIES_PC_RST   = 15'h0000;

    //------------------------------------------------------------------
    // Execution states
    //------------------------------------------------------------------
    typedef enum logic [1:0] {
        CIES_ST_EXEC  = 2'b01,
        CIES_ST_FLUSH = 2'b10
    } cies_state_t;

endpackage

// file: cies_alu.sv
`timescale 1ns/10ps
//----------------------------------------------------------------------
// Arithmetic for the subset
//----------------------------------------------------------------------
module cies_alu (
    input  wire logic [7:0] file_data_i,
    input  wire logic [7:0] acc_i,
    input  wire logic [7:0] lit_i,
    output logic      [7:0] inc_o,
    output logic      [7:0] dec_o,
    output logic      [7:0] or_o
);
    import cies_pkg::*;

    // Wrapping increment, decrement and literal OR
    assign inc_o = 8'(file_data_i + 8'h01);          // RQ9
    assign dec_o = 8'(file_data_i - 8'h01);          // RQ9
    assign or_o  = acc_i | lit_i;                    // RQ7
endmodule // cies_alu

// file: cies_core.sv
`timescale 1ns/10ps
//----------------------------------------------------------------------
// Instruction subset execution
//----------------------------------------------------------------------
module cies_core (
    input  wire logic                  clk_sys_i,
    input  wire logic                  reset_n_i,
    input  wire logic                  instr_valid_i,
    input  wire logic [13:0]           instr_i,
    input  wire logic [7:0]            file_rdata_i,
    input  wire logic [7:0]            pc_high_latch_i,
    input  wire logic [cies_pkg::CIES_PC_W-1:0] pc_i,
    output logic [cies_pkg::CIES_FILE_ADDR_W-1:0] file_addr_o,
    output logic [7:0]                 file_wdata_o,
    output logic                       file_we_o,
    output logic [7:0]                 acc_o,
    output logic                       zero_flag_o,
    output logic                       zero_we_o,
    output logic [cies_pkg::CIES_PC_W-1:0] pc_o,
    output logic                       pc_load_o,
    output logic                       flush_o,
    output logic                       busy_o
);
    import cies_pkg::*;

    //------------------------------------------------------------------
    // Decode
    //------------------------------------------------------------------
    logic [7:0] inc_v;
    logic [7:0] dec_v;
    logic [7:0] or_v;
    logic       clear_accumulator_op;
    logic       decrement_skip_zero_op;
    logic       increment_skip_zero_op;
    logic       increment_file_op;
    logic       or_literal_op;
    logic       unconditional_branch_op;
    logic       dest_file;
    logic       exec_en;
    cies_state_t state_r;
    cies_state_t state_nxt;

    // Opcode field match, shared by the three file-register decodes and the literal OR
    function automatic logic opc_hit(input logic [13:0] word,
                                     input logic [5:0]  opc);
        return word[13:8] == opc;
    endfunction

    // Instruction is executed only outside a flush cycle
    assign exec_en = instr_valid_i && (state_r == CIES_ST_EXEC);
    assign clear_accumulator_op    = exec_en && instr_i == CIES_CLEAR_ACC_WORD;
    assign decrement_skip_zero_op  = exec_en
                                  && opc_hit(instr_i, CIES_DEC_SKIP_OPC);
    assign increment_skip_zero_op  = exec_en
                                  && opc_hit(instr_i, CIES_INC_SKIP_OPC);
    assign increment_file_op       = exec_en
                                  && opc_hit(instr_i, CIES_INC_FILE_OPC);
    assign or_literal_op           = exec_en
                                  && opc_hit(instr_i, CIES_OR_LIT_OPC);
    assign unconditional_branch_op = exec_en
                                  && instr_i[13:11] == CIES_BRANCH_OPC;
    assign dest_file   = instr_i[CIES_DEST_BIT];                  // RQ2
    assign file_addr_o = instr_i[CIES_FILE_ADDR_W-1:0];           // RQ2

    cies_alu u_alu (
        .file_data_i (file_rdata_i),
        .acc_i       (acc_o),
        .lit_i       (instr_i[7:0]),
        .inc_o       (inc_v),
        .dec_o       (dec_v),
        .or_o        (or_v)
    );

    //------------------------------------------------------------------
    // Step result
    //------------------------------------------------------------------
    logic [7:0] result;
    logic       skip_op;
    logic       file_step_op;
    logic       skip_hit;

    // Increment and decrement share one result and destination path
    assign skip_op      = increment_skip_zero_op || decrement_skip_zero_op;
    assign file_step_op = increment_file_op || skip_op;
    assign result       = decrement_skip_zero_op ? dec_v : inc_v;
    assign skip_hit     = skip_op && (result == 8'h00);          // RQ3 RQ4

    //------------------------------------------------------------------
    // Accumulator
    //------------------------------------------------------------------
    logic [7:0] acc_nxt;

    // Clear, literal OR, or a step result steered to the accumulator
    always_comb begin
        acc_nxt = acc_o;
        if (clear_accumulator_op) begin
            acc_nxt = 8'h00;                                      // RQ1
        end else if (or_literal_op) begin
            acc_nxt = or_v;                                       // RQ7
        end else if (file_step_op && !dest_file) begin
            acc_nxt = result;                                     // RQ2
        end
    end

    // Accumulator register
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            acc_o <= CIES_ACC_RST;
        end else begin
            acc_o <= acc_nxt;
        end
    end

    //------------------------------------------------------------------
    // Zero flag
    //------------------------------------------------------------------
    logic zero_nxt;
    logic zero_we_nxt;

    // Skip steps and branches leave the flag alone; clear, literal OR and increment rewrite it
    always_comb begin
        zero_nxt    = zero_flag_o;
        zero_we_nxt = 1'b0;
        if (clear_accumulator_op) begin
            zero_nxt    = 1'b1;                                   // RQ1
            zero_we_nxt = 1'b1;
        end else if (or_literal_op) begin
            zero_nxt    = (or_v == 8'h00);                        // RQ7 RQ9
            zero_we_nxt = 1'b1;
        end else if (increment_file_op) begin
            zero_nxt    = (result == 8'h00);                      // RQ8 RQ9
            zero_we_nxt = 1'b1;
        end
    end

    // Flag register and its one-cycle update strobe
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            zero_flag_o <= 1'b0;
            zero_we_o   <= 1'b0;
        end else begin
            zero_flag_o <= zero_nxt;
            zero_we_o   <= zero_we_nxt;
        end
    end

    //------------------------------------------------------------------
    // File write-back
    //------------------------------------------------------------------
    logic [7:0] wdata_nxt;
    logic       we_nxt;

    // Step results with the destination bit set go back to the file
    always_comb begin
        wdata_nxt = file_wdata_o;
        we_nxt    = 1'b0;
        if (file_step_op && dest_file) begin                      // RQ2
            wdata_nxt = result;
            we_nxt    = 1'b1;
        end
    end

    // Write data holds; the strobe stands for one cycle
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            file_wdata_o <= 8'h00;
            file_we_o    <= 1'b0;
        end else begin
            file_wdata_o <= wdata_nxt;
            file_we_o    <= we_nxt;
        end
    end

    //------------------------------------------------------------------
    // Branch target
    //------------------------------------------------------------------
    logic [CIES_PC_W-1:0] pc_nxt;
    logic                 pc_load_nxt;

    // Target from the literal and the high-address latch
    always_comb begin
        pc_nxt      = pc_o;
        pc_load_nxt = 1'b0;
        if (unconditional_branch_op) begin
            pc_nxt      = {pc_high_latch_i[CIES_LATCH_HI:CIES_LATCH_LO],
                           instr_i[CIES_LIT_W-1:0]};              // RQ5
            pc_load_nxt = 1'b1;
        end
    end

    // Target holds; the load strobe stands for one cycle
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pc_o      <= CIES_PC_RST;
            pc_load_o <= 1'b0;
        end else begin
            pc_o      <= pc_nxt;
            pc_load_o <= pc_load_nxt;
        end
    end

    //------------------------------------------------------------------
    // Sequencer
    //------------------------------------------------------------------
    // A taken branch or a skip on zero turns the next cycle into a flush
    always_comb begin
        state_nxt = CIES_ST_EXEC;
        unique case (state_r)
            CIES_ST_EXEC: begin
                if (unconditional_branch_op || skip_hit) begin
                    state_nxt = CIES_ST_FLUSH;                    // RQ3 RQ4 RQ6
                end
            end
            CIES_ST_FLUSH: begin
                state_nxt = CIES_ST_EXEC;
            end
            default: begin
                state_nxt = CIES_ST_EXEC;
            end
        endcase
    end

    // Sequencer register
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_r <= CIES_ST_EXEC;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Flush cycle runs a no-operation in place of the fetched word
    assign flush_o = (state_r == CIES_ST_FLUSH);                  // RQ3 RQ4 RQ6
    assign busy_o  = flush_o;

    // Ignore pc_i except as context; hold it read for completeness
    logic unused_pc;
    assign unused_pc = ^pc_i;
endmodule // cies_core

// file: cies_core_asserts.sv
`timescale 1ns/10ps
//--------------------
// Port checker
//--------------------
module cies_core_asserts (
    input wire logic        clk_sys_i,
    input wire logic        reset_n_i,
    input wire logic        instr_valid_i,
    input wire logic [13:0] instr_i,
    input wire logic [7:0]  file_rdata_i,
    input wire logic [7:0]  pc_high_latch_i,
    input wire logic [6:0]  file_addr_o,
    input wire logic [7:0]  file_wdata_o,
    input wire logic        file_we_o,
    input wire logic [7:0]  acc_o,
    input wire logic        zero_flag_o,
    input wire logic        zero_we_o,
    input wire logic [14:0] pc_o,
    input wire logic        pc_load_o,
    input wire logic        flush_o
);
    import cies_pkg::*;
    logic       tk;
    logic [5:0] op;
    logic [7:0] res;
    // Taken word, its opcode and the value at its destination
    assign tk = instr_valid_i && !flush_o;
    assign op = instr_i[13:8];
    assign res = file_we_o ? file_wdata_o : acc_o;
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!reset_n_i);
    chk_clear_acc: assert property (tk && instr_i == CIES_CLEAR_ACC_WORD
        |=> acc_o == 8'h00 && zero_flag_o && zero_we_o) else $error("clr");
    chk_addr_field: assert property (file_addr_o == instr_i[6:0])
        else $error("addr");
    chk_dec_skip: assert property (tk && op == CIES_DEC_SKIP_OPC
        |=> res == $past(file_rdata_i) - 8'h01 && !zero_we_o
        && flush_o == ($past(file_rdata_i) == 8'h01)) else $error("dec");
    chk_inc_skip: assert property (tk && op == CIES_INC_SKIP_OPC
        |=> res == $past(file_rdata_i) + 8'h01 && !zero_we_o
        && flush_o == ($past(file_rdata_i) == 8'hff)) else $error("incs");
    chk_inc_file: assert property (tk && op == CIES_INC_FILE_OPC
        |=> file_we_o == $past(instr_i[7]) && zero_we_o && !flush_o
        && zero_flag_o == (res == 8'h00)) else $error("inc");
    chk_or_lit: assert property (tk && op == CIES_OR_LIT_OPC
        |=> acc_o == ($past(acc_o) | $past(instr_i[7:0])) && zero_we_o
        && zero_flag_o == (acc_o == 8'h00)) else $error("or");
    chk_branch_pc: assert property (tk && instr_i[13:11] == 3'h5
        |=> pc_load_o && pc_o == {$past(pc_high_latch_i[6:3]),
        $past(instr_i[10:0])}) else $error("branch");
    chk_branch_flush: assert property (tk && instr_i[13:11] == 3'h5
        |=> flush_o ##1 !flush_o && !pc_load_o) else $error("flush");
endmodule // cies_core_asserts

bind cies_core cies_core_asserts cies_core_asserts_inst (.clk_sys_i,
    .reset_n_i, .instr_valid_i, .instr_i, .file_rdata_i, .pc_high_latch_i,
    .file_addr_o, .file_wdata_o, .file_we_o, .acc_o, .zero_flag_o,
    .zero_we_o, .pc_o, .pc_load_o, .flush_o);

// file: tb.sv
`timescale 1ns/10ps
//--------------------
// Testbench
//--------------------
module tb;
    import cies_pkg::*;
    logic        clk_sys_i = 1'b0, reset_n_i = 1'b0, instr_valid_i = 1'b0;
    logic [13:0] instr_i = 14'h0000;
    logic [7:0]  file_rdata_i = 8'h00, pc_high_latch_i = 8'h00;
    logic [7:0]  file_wdata_o, acc_o;
    logic [6:0]  file_addr_o;
    logic        file_we_o, zero_flag_o, zero_we_o, pc_load_o, flush_o, busy_o;
    logic [14:0] pc_o;
    int          num_errors = 0, total_checks = 0;
    // Clock
    initial begin
        forever #25 clk_sys_i = ~clk_sys_i;
    end
    cies_core cies_core_inst (.clk_sys_i, .reset_n_i, .instr_valid_i,
        .instr_i, .file_rdata_i, .pc_high_latch_i, .pc_i(15'h0000),
        .file_addr_o, .file_wdata_o, .file_we_o, .acc_o, .zero_flag_o,
        .zero_we_o, .pc_o, .pc_load_o, .flush_o, .busy_o);
    // Compare and count
    task chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Present one word for one edge, results settled on return
    task issue(input logic v, input logic [13:0] w, input logic [7:0] r);
        instr_valid_i = v;
        instr_i = w;
        file_rdata_i = r;
        @(posedge clk_sys_i);
        #1;
    endtask
    task t_acc();
        issue(1'b1, {CIES_OR_LIT_OPC, 8'ha5}, 8'h00);
        issue(1'b1, {CIES_OR_LIT_OPC, 8'h18}, 8'h00);
        chk({zero_we_o, zero_flag_o, 6'h00, acc_o}, 16'h80bd);
        issue(1'b1, CIES_CLEAR_ACC_WORD, 8'h00);
        chk({zero_flag_o, 7'h00, acc_o}, 16'h8000);
        issue(1'b1, {CIES_OR_LIT_OPC, 8'h00}, 8'h00);
        chk({14'h0000, zero_we_o, zero_flag_o}, 16'h0003);
        $display("test acc done");
    endtask
    task t_file();
        issue(1'b1, {CIES_INC_FILE_OPC, 8'hff}, 8'hff);
        chk({file_addr_o, file_we_o, file_wdata_o}, 16'hff00);
        chk({14'h0000, zero_we_o, zero_flag_o}, 16'h0003);
        issue(1'b1, {CIES_INC_FILE_OPC, 8'h05}, 8'h12);
        chk({file_we_o, zero_flag_o, 6'h00, acc_o}, 16'h0013);
        issue(1'b1, {CIES_DEC_SKIP_OPC, 8'h02}, 8'h00);
        chk({flush_o, zero_we_o, 6'h00, acc_o}, 16'h00ff);
        $display("test file done");
    endtask
    task t_skip();
        issue(1'b1, {CIES_INC_SKIP_OPC, 8'h03}, 8'h40);
        chk({flush_o, zero_we_o, 6'h00, acc_o}, 16'h0041);
        issue(1'b1, {CIES_DEC_SKIP_OPC, 8'h81}, 8'h01);
        chk({flush_o, file_we_o, 6'h00, file_wdata_o}, 16'hc000);
        issue(1'b1, {CIES_BRANCH_OPC, 11'h123}, 8'h00);
        chk({13'h0000, pc_load_o, file_we_o, flush_o}, 16'h0000);
        issue(1'b1, {CIES_INC_SKIP_OPC, 8'h83}, 8'hff);
        chk({flush_o, file_we_o, 6'h00, file_wdata_o}, 16'hc000);
        issue(1'b1, CIES_CLEAR_ACC_WORD, 8'h00);
        chk({flush_o, zero_we_o, 6'h00, acc_o}, 16'h0041);
        $display("test skip done");
    endtask
    task t_branch();
        pc_high_latch_i = 8'hd7;
        issue(1'b1, {CIES_BRANCH_OPC, 11'h5a5}, 8'h00);
        chk({pc_load_o, pc_o}, 16'hd5a5);
        chk({14'h0000, busy_o, flush_o}, 16'h0003);
        issue(1'b1, CIES_CLEAR_ACC_WORD, 8'h00);
        chk({flush_o, pc_load_o, zero_we_o, 5'h00, acc_o}, 16'h0041);
        pc_high_latch_i = 8'h87;
        issue(1'b1, {CIES_BRANCH_OPC, 11'h7ff}, 8'h00);
        chk({pc_load_o, pc_o}, 16'h87ff);
        issue(1'b0, 14'h0000, 8'h00);
        $display("test branch done");
    endtask
    // Verdict and end of run
    task end_of_test();
        $display("checks=%0d errors=%0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // Reset, then the scenarios
    initial begin
        repeat (6) @(posedge clk_sys_i);
        #1;
        reset_n_i = 1'b1;
        t_acc();
        t_file();
        t_skip();
        t_branch();
        end_of_test();
    end
    // Watchdog
    initial begin
        #20000;
        num_errors++;
        end_of_test();
    end
endmodule // tb
